// file: cfg_regs_pkg.sv
// Package: register map, field positions and carrier structs for the configuration bank
`default_nettype none
package cfg_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] idx_pattern_b_split_word = 8'h1a;
  localparam logic [7:0] idx_pattern_b_alt_upper = 8'h1b;
  localparam logic [7:0] idx_appended_tag_bits = 8'h1c;
  localparam logic [7:0] idx_calib_and_init_key = 8'h33;
  localparam logic [7:0] idx_calib_enable_extra = 8'h34;
  localparam logic [7:0] idx_bandwidth_and_powerdown = 8'hc0;
  localparam logic [7:0] idx_reference_and_output_format = 8'hc1;
  // Second converter pattern enable and selected-pattern bits (own register)
  localparam logic [7:0] idx_pattern_control = 8'hd0;

  localparam int reg_width = 16;
  localparam logic [15:0] reg_reset = 16'h0000;

  // Field positions
  localparam int pos_alt_low = 8;
  localparam int pos_pri_high = 0;
  localparam int pos_tag_b = 8;
  localparam int pos_tag_a = 0;
  localparam int pos_gcal_b = 13;
  localparam int pos_gcal_a = 6;
  localparam int pos_init_key = 4;
  localparam int pos_gcal_c = 4;
  localparam int pos_bw = 2;
  localparam int pos_pd = 0;
  localparam int pos_ref_dis = 11;
  localparam int pos_lanes = 9;
  localparam int pos_rate = 8;
  localparam int pos_pat_en = 0;
  localparam int pos_pat_sel = 1;

  localparam logic [1:0] init_key_open = 2'h3;
  localparam logic [1:0] pd_none = 2'h0;
  localparam logic [1:0] pd_low_group = 2'h1;
  localparam logic [1:0] pd_high_group = 2'h2;
  localparam logic [1:0] pd_all = 2'h3;

  // Decoded configuration handed to the rest of the device
  typedef struct packed {
    logic [23:0] second_conv_primary_pattern;
    logic [23:0] second_conv_alt_pattern;
    logic [7:0] tag_low_group;
    logic [7:0] tag_high_group;
    logic gain_calib_enable_a;
    logic gain_calib_enable_b;
    logic gain_calib_enable_c;
    logic init_access;
    logic [7:0] channel_bandwidth_select;
    logic [7:0] channel_powered_down;
    logic internal_reference_disable;
    logic single_lane;
    logic single_data_rate;
  } cfg_s;

endpackage : cfg_regs_pkg
`default_nettype wire

// file: pattern_mux.sv
// Small module: replaces one converter's result word with a test pattern when enabled
`default_nettype none
module pattern_mux #(
  parameter int data_width = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Selection
  input wire logic enable,
  input wire logic sel_alt,
  input wire logic [data_width-1:0] primary,
  input wire logic [data_width-1:0] alternate,
  // Data path
  input wire logic [data_width-1:0] result_in,
  output logic [data_width-1:0] result_out
);

  typedef struct packed {
    logic [data_width-1:0] out;
  } mux_state_s;

  mux_state_s state_reg;
  mux_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next.out = result_in;
    end else if (sel_alt) begin
      state_next.out = alternate;
    end else begin
      state_next.out = primary;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign result_out = state_reg.out;

endmodule : pattern_mux
`default_nettype wire

// file: adc_pattern_calib_config_regs.sv
// Configuration register bank on a classic Wishbone slave, with test-pattern substitution
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Offset 1Ah bits 15-8 hold the low byte of the alternate pattern.
// - Offset 1Ah bits 7-0 hold bits 23-16 of the primary pattern.
// - Offset 1Bh holds bits 23-8 of the alternate pattern.
// - Offset 1Ch holds user tags: high byte channels 5-8, low byte 1-4.
// - Three global gain calibration enables: 33h bits 13, 6 and 34h bit 4.
// - Init key 11b at 33h bits 5-4 opens initialization; host restores 00b.
// - Offset C0h bits 9-2 select per-channel bandwidth, MSB channel eight.
// - Offset C0h bits 1-0 power down channel groups 1-4, 5-8 or all.
// - All registers sixteen bits, read/write, zero after reset; D0h also stores primary pattern bits 15-0 in its bits 31-16.
// - Pattern enable replaces channel 5-8 results with the selected pattern.
// - Lane bit: 0 two lanes per converter, 1 one lane.
// - Rate bit: 0 double data rate, 1 single data rate.
module adc_pattern_calib_config_regs #(
  parameter int result_width = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Second converter data path
  input wire logic [result_width-1:0] second_conv_result,
  output logic [result_width-1:0] second_conv_data_out,
  // Decoded configuration
  output cfg_regs_pkg::cfg_s cfg
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] split_word;
    logic [15:0] alt_upper;
    logic [15:0] tag_bits;
    logic [15:0] calib_key;
    logic [15:0] calib_extra;
    logic [15:0] bw_pd;
    logic [15:0] ref_fmt;
    logic [15:0] pat_ctrl;
    logic [15:0] primary_low;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } bank_state_s;

  bank_state_s state_reg;
  bank_state_s state_next;

  logic [7:0] index;
  logic word_aligned;
  logic hit;
  logic [15:0] read_word;

  // Registers take one aligned word; index is the register offset
  assign index = wb_adr_i[9:2];
  assign word_aligned = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[31:10] == 22'h000000);

  // Merge a write into the low sixteen bits honouring byte lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_value,
    input logic [31:0] wdata,
    input logic [3:0] sel
  );
    logic [15:0] merged;
    merged = old_value;
    if (sel[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (sel[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return merged;
  endfunction : lane_merge

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    hit = 1'b1;
    read_word = 16'h0000;
    unique case (index)
      cfg_regs_pkg::idx_pattern_b_split_word: read_word = state_reg.split_word;
      cfg_regs_pkg::idx_pattern_b_alt_upper: read_word = state_reg.alt_upper;
      cfg_regs_pkg::idx_appended_tag_bits: read_word = state_reg.tag_bits;
      cfg_regs_pkg::idx_calib_and_init_key: read_word = state_reg.calib_key;
      cfg_regs_pkg::idx_calib_enable_extra: read_word = state_reg.calib_extra;
      cfg_regs_pkg::idx_bandwidth_and_powerdown: read_word = state_reg.bw_pd;
      cfg_regs_pkg::idx_reference_and_output_format: read_word = state_reg.ref_fmt;
      cfg_regs_pkg::idx_pattern_control: read_word = state_reg.pat_ctrl;
      default: hit = 1'b0;
    endcase
    if (!word_aligned) begin
      hit = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic req;
    req = 1'b0;
    state_next = state_reg;
    req = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
    // Answer lasts one cycle; no request is taken while it is out, so the master can drop stb between accesses
    state_next.ack = req && hit;
    state_next.err = req && !hit;
    if (req && hit && !wb_we_i) begin
      state_next.rdata = {16'h0000, read_word};
    end
    if (req && hit && wb_we_i) begin
      // Reserved bits are stored as written; the host keeps them zero
      unique case (index)
        cfg_regs_pkg::idx_pattern_b_split_word:
          state_next.split_word = lane_merge(state_reg.split_word, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_pattern_b_alt_upper:
          state_next.alt_upper = lane_merge(state_reg.alt_upper, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_appended_tag_bits:
          state_next.tag_bits = lane_merge(state_reg.tag_bits, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_calib_and_init_key:
          state_next.calib_key = lane_merge(state_reg.calib_key, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_calib_enable_extra:
          state_next.calib_extra = lane_merge(state_reg.calib_extra, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_bandwidth_and_powerdown:
          state_next.bw_pd = lane_merge(state_reg.bw_pd, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_reference_and_output_format:
          state_next.ref_fmt = lane_merge(state_reg.ref_fmt, wb_dat_i, wb_sel_i);
        cfg_regs_pkg::idx_pattern_control: begin
          state_next.pat_ctrl = lane_merge(state_reg.pat_ctrl, wb_dat_i, wb_sel_i);
          // Low sixteen primary bits live beside the enable so the pattern is complete
          if (wb_sel_i[2]) begin
            state_next.primary_low[7:0] = wb_dat_i[23:16];
          end
          if (wb_sel_i[3]) begin
            state_next.primary_low[15:8] = wb_dat_i[31:24];
          end
        end
        default: state_next = state_next;
      endcase
    end
    if (req && hit && !wb_we_i && index == cfg_regs_pkg::idx_pattern_control) begin
      state_next.rdata = {state_reg.primary_low, read_word};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_err_o = state_reg.err;
  assign wb_dat_o = state_reg.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded outputs

  logic [23:0] primary_pattern;
  logic [23:0] alt_pattern;
  logic [1:0] pd_code;

  assign primary_pattern = {state_reg.split_word[cfg_regs_pkg::pos_pri_high +: 8],
                            state_reg.primary_low};
  assign alt_pattern = {state_reg.alt_upper,
                        state_reg.split_word[cfg_regs_pkg::pos_alt_low +: 8]};
  assign pd_code = state_reg.bw_pd[cfg_regs_pkg::pos_pd +: 2];

  always_comb begin
    cfg = '0;
    cfg.second_conv_primary_pattern = primary_pattern;
    cfg.second_conv_alt_pattern = alt_pattern;
    cfg.tag_low_group = state_reg.tag_bits[cfg_regs_pkg::pos_tag_a +: 8];
    cfg.tag_high_group = state_reg.tag_bits[cfg_regs_pkg::pos_tag_b +: 8];
    // Kept separate: how the three enables combine is not defined
    cfg.gain_calib_enable_a = state_reg.calib_key[cfg_regs_pkg::pos_gcal_a];
    cfg.gain_calib_enable_b = state_reg.calib_key[cfg_regs_pkg::pos_gcal_b];
    cfg.gain_calib_enable_c = state_reg.calib_extra[cfg_regs_pkg::pos_gcal_c];
    cfg.init_access = state_reg.calib_key[cfg_regs_pkg::pos_init_key +: 2]
                      == cfg_regs_pkg::init_key_open;
    cfg.channel_bandwidth_select = state_reg.bw_pd[cfg_regs_pkg::pos_bw +: 8];
    unique case (pd_code)
      cfg_regs_pkg::pd_none: cfg.channel_powered_down = 8'h00;
      cfg_regs_pkg::pd_low_group: cfg.channel_powered_down = 8'h0f;
      cfg_regs_pkg::pd_high_group: cfg.channel_powered_down = 8'hf0;
      cfg_regs_pkg::pd_all: cfg.channel_powered_down = 8'hff;
    endcase
    cfg.internal_reference_disable = state_reg.ref_fmt[cfg_regs_pkg::pos_ref_dis];
    cfg.single_lane = state_reg.ref_fmt[cfg_regs_pkg::pos_lanes];
    cfg.single_data_rate = state_reg.ref_fmt[cfg_regs_pkg::pos_rate];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test pattern substitution for channels five to eight

  logic [result_width-1:0] pri_sized;
  logic [result_width-1:0] alt_sized;

  assign pri_sized = result_width'(primary_pattern);
  assign alt_sized = result_width'(alt_pattern);

  pattern_mux #(
    .data_width(result_width)
  ) u_second_mux (
    .clk(clk),
    .srst(srst),
    .enable(state_reg.pat_ctrl[cfg_regs_pkg::pos_pat_en]),
    .sel_alt(state_reg.pat_ctrl[cfg_regs_pkg::pos_pat_sel]),
    .primary(pri_sized),
    .alternate(alt_sized),
    .result_in(second_conv_result),
    .result_out(second_conv_data_out)
  );

endmodule : adc_pattern_calib_config_regs
`default_nettype wire

// file: cfg_regs_sva.sv
// Checker for bus answers, register decode and pattern substitution
`default_nettype none
module cfg_regs_sva #(
  parameter int result_width = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Data path and decode
  input wire logic [result_width-1:0] second_conv_result,
  input wire logic [result_width-1:0] second_conv_data_out,
  input wire cfg_regs_pkg::cfg_s cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic mapped;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i inside {32'h68, 32'h6c, 32'h70, 32'hcc, 32'hd0, 32'h300, 32'h304,
    32'h340};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_req_answer: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered in one cycle");
  a_answer_map: assert property (wb_ack_o || wb_err_o |-> wb_err_o != $past(mapped))
    else $error("answer kind does not match address");
  a_pd_decode: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0])
    && $past(wb_adr_i) == 32'h300 |-> cfg.channel_powered_down ==
    {{4{$past(wb_dat_i[1])}}, {4{$past(wb_dat_i[0])}}}) else $error("power-down decode wrong");
  a_bw_write: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_sel_i[1:0]) == 2'h3
    && $past(wb_adr_i) == 32'h300 |-> cfg.channel_bandwidth_select == $past(wb_dat_i[9:2]))
    else $error("bandwidth selects wrong");
  a_init_key: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0])
    && $past(wb_adr_i) == 32'hcc |-> cfg.init_access == ($past(wb_dat_i[5:4]) == 2'h3))
    else $error("init access wrong");
  a_cfg_hold: assert property (!wb_ack_o |-> $stable(cfg))
    else $error("configuration changed without a write");
  a_data_sub: assert property (second_conv_data_out != $past(second_conv_result)
    |-> second_conv_data_out == $past(cfg.second_conv_primary_pattern)
    || second_conv_data_out == $past(cfg.second_conv_alt_pattern)) else $error("bad data out");
endmodule : cfg_regs_sva

bind adc_pattern_calib_config_regs cfg_regs_sva #(.result_width(result_width)) u_sva (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .second_conv_result(second_conv_result),
  .second_conv_data_out(second_conv_data_out), .cfg(cfg));
`default_nettype wire

// file: host_bus_model.sv
// Host model: classic single-cycle bus master programming the bank
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic clk,
  // Bus
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [31:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic [31:0] rdat,
  input wire logic ack,
  input wire logic err
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    sel = 4'h0;
    dat = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Writable bits per register; reserved bits are never set
  function automatic logic [31:0] legal(input logic [7:0] i);
    case (i)
      8'h33: legal = 32'h2070;
      8'h34: legal = 32'h10;
      8'hc0: legal = 32'h3ff;
      8'hc1: legal = 32'hb00;
      8'hd0: legal = 32'hffff0003;
      default: legal = 32'hffff;
    endcase
  endfunction : legal
  task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk); while (!(ack || err));
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data must not look like a still-valid value
    dat <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// file: adc_pattern_calib_config_regs_bench.sv
// Bench for the configuration bank: registers, decode and pattern path
`default_nettype none
module adc_pattern_calib_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc, stb, we, ack, err, e;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel;
  logic [23:0] res = 24'h0;
  logic [23:0] dout, r;
  cfg_regs_pkg::cfg_s cfg, ecfg;
  logic [31:0] mdl [8];
  logic [7:0] idx [8] = '{8'h1a, 8'h1b, 8'h1c, 8'h33, 8'h34, 8'hc0, 8'hc1, 8'hd0};
  logic [23:0] exq [$];
  int num_errors = 0;
  int num_checks = 0;
  int seed = 56419;
  int cycles = 0;
  always #20 clk = ~clk;
  adc_pattern_calib_config_regs #(.result_width(24)) u_adc_pattern_calib_config_regs (
    .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .second_conv_result(res), .second_conv_data_out(dout), .cfg(cfg));
  host_bus_model u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wdat), .rdat(rdat), .ack(ack), .err(err));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // Model follows byte lanes; unselected lanes carry data that must be ignored
  task automatic wr(input int i, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & u_host.legal(idx[i]);
    u_host.xfer(1'b1, {22'h0, idx[i], 2'h0}, s, d & u_host.legal(idx[i]), q, e);
    mdl[i] = (mdl[i] & ~m) | (d & m);
    check(e, 1'b0, "write refused");
  endtask : wr
  task automatic rd(input int i);
    u_host.xfer(1'b0, {22'h0, idx[i], 2'h0}, 4'hf, 32'h0, q, e);
    check({e, q}, {1'b0, mdl[i]}, "read back");
  endtask : rd
  task automatic chk_cfg();
    ecfg = {mdl[0][7:0], mdl[7][31:16], mdl[1][15:0], mdl[0][15:8], mdl[2][7:0],
      mdl[2][15:8], mdl[3][6], mdl[3][13], mdl[4][4], mdl[3][5:4] == 2'h3, mdl[5][9:2],
      {4{mdl[5][1]}}, {4{mdl[5][0]}}, mdl[6][11], mdl[6][9], mdl[6][8]};
    check(cfg, ecfg, "decoded configuration");
  endtask : chk_cfg
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    foreach (mdl[i]) mdl[i] = 32'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd(i);
    chk_cfg();
    $display("Test reset values done");
    for (int n = 0; n < 48; n++) begin
      wr(n % 8, 4'($random(seed)), $random(seed));
      rd(n % 8);
      chk_cfg();
    end
    $display("Test random access done");
    for (int c = 0; c < 4; c++) begin
      // Low two bits forced so every power-down code is visited once
      wr(5, 4'h3, (32'($random(seed)) & 32'hfffffffc) | 32'(c));
      chk_cfg();
    end
    wr(3, 4'h1, 32'h30);
    chk_cfg();
    wr(3, 4'h1, 32'h0);
    chk_cfg();
    u_host.xfer(1'b1, 32'h3fc, 4'hf, 32'hffff, q, e);
    check(e, 1'b1, "unmapped write");
    u_host.xfer(1'b1, 32'h301, 4'hf, 32'hffff, q, e);
    check(e, 1'b1, "misaligned write");
    u_host.xfer(1'b0, 32'h3fc, 4'hf, 32'h0, q, e);
    check(e, 1'b1, "unmapped read");
    chk_cfg();
    $display("Test codes and refusals done");
    for (int mo = 0; mo < 3; mo++) begin
      wr(7, 4'hf, {16'($random(seed)), 14'h0, mo == 2, mo != 0});
      chk_cfg();
      exq.delete();
      repeat (12) begin
        @(posedge clk);
        if (exq.size() == 2) check(dout, exq.pop_front(), "data path");
        r = 24'($random(seed));
        res <= r;
        exq.push_back(mdl[7][0] ? (mdl[7][1] ? ecfg.second_conv_alt_pattern :
          ecfg.second_conv_primary_pattern) : r);
      end
    end
    $display("Test pattern path done");
    summarize();
  end
endmodule : adc_pattern_calib_config_regs_bench
`default_nettype wire
